// >>> rtl/aid_consts.vh
/*
 * datapath constants: op codes, flag positions, i/o indices, cycle counts.
 * assumes inclusion by bare name.
 */
`ifndef AID_CONSTS_VH
`define AID_CONSTS_VH

// operation codes
`define AID_OP_ADD 5'h00
`define AID_OP_ADD_CARRY 5'h01
`define AID_OP_ADD_IMM_TO_PAIR 5'h02
`define AID_OP_SUB 5'h03
`define AID_OP_SUBTRACT_IMM 5'h04
`define AID_OP_SUBTRACT_REGS_WITH_CARRY 5'h05
`define AID_OP_SUBTRACT_IMM_WITH_CARRY 5'h06
`define AID_OP_SUBTRACT_IMM_FROM_PAIR 5'h07
`define AID_OP_AND 5'h08
`define AID_OP_AND_WITH_IMM 5'h09
`define AID_OP_OR 5'h0a
`define AID_OP_OR_WITH_IMM 5'h0b
`define AID_OP_XOR_REGS 5'h0c
`define AID_OP_ONES_COMPLEMENT 5'h0d
`define AID_OP_TWOS_COMPLEMENT 5'h0e
`define AID_OP_SET_MASK_BITS 5'h0f
`define AID_OP_CLEAR_MASK_BITS 5'h10
`define AID_OP_INCREMENT 5'h11
`define AID_OP_DECREMENT_REG 5'h12
`define AID_OP_TEST_REG 5'h13
`define AID_OP_ZERO_REG 5'h14
`define AID_OP_IO_BIT_SET 5'h15
`define AID_OP_IO_BIT_CLEAR 5'h16
`define AID_OP_SKIP_IF_IO_BIT_ONE 5'h17
`define AID_OP_SKIP_IF_IO_BIT_ZERO 5'h18

// status flag bit positions
`define AID_FLAG_C 0
`define AID_FLAG_Z 1
`define AID_FLAG_N 2
`define AID_FLAG_V 3
`define AID_FLAG_S 4
`define AID_FLAG_H 5

// byte constants used by the operations
`define AID_ALL_ONES 8'hff
`define AID_ZERO_BYTE 8'h00
`define AID_MOST_POS 8'h7f
`define AID_MOST_NEG 8'h80

// i/o space indices and the write-one-to-clear entry
`define AID_IO_HI 6'h1f
`define AID_IO_ENTRIES 32
`define AID_SREG_IDX 6'h3f
`define AID_W1C_IDX 5'h0b
`define AID_W1C_MASK 8'h2f
`define AID_IO_RST 8'h00
`define AID_FLAGS_RST 8'h00

// cycles per operation class
`define AID_CYC_BYTE 1
`define AID_CYC_WORD 2
`define AID_CYC_BIT 2

`endif

// >>> rtl/aid_io_space.v
/*
 * bit-accessible i/o space: 32 byte entries in flip-flops, a bus write
 * port, a single-bit write port and two combinational read ports.
 * assumes peripheral flag set pulses come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aid_consts.vh"

module aid_io_space (
    input wire mclk,
    input wire rst,
    input wire wr_en,
    input wire [4:0] wr_idx,
    input wire [7:0] wr_data,
    input wire bit_en,
    input wire [4:0] bit_idx,
    input wire [2:0] bit_sel,
    input wire bit_val,
    input wire [7:0] hw_set,
    input wire [4:0] rd_a_idx,
    output wire [7:0] rd_a_data,
    input wire [4:0] rd_b_idx,
    output wire [7:0] rd_b_data
);
    wire [8*`AID_IO_ENTRIES-1:0] flat; // all entries side by side

    genvar gi;
    generate
        for (gi = 0; gi < `AID_IO_ENTRIES; gi = gi + 1) begin : g_ent
            reg [7:0] ent_reg; // stored byte
            reg [7:0] ent_next; // next byte
            wire [7:0] w1c_m; // bits that clear on a written one
            assign w1c_m = (gi == `AID_W1C_IDX) ? `AID_W1C_MASK : 8'h00;
            // whole-byte write, then single-bit write, then hardware set
            always @* begin
                ent_next = ent_reg;
                if (wr_en && wr_idx == gi) begin
                    // ordinary bits take data, flag bits clear on a one
                    ent_next = (wr_data & ~w1c_m) | (ent_reg & w1c_m & ~wr_data);
                end
                if (bit_en && bit_idx == gi) begin
                    // only the addressed bit moves; other flags stay put
                    if (w1c_m[bit_sel]) begin
                        if (bit_val)
                            ent_next[bit_sel] = 1'b0;
                    end else begin
                        ent_next[bit_sel] = bit_val;
                    end
                end
                // set wins over any clear in the same cycle
                ent_next = ent_next | (hw_set & w1c_m);
            end
            always @(posedge mclk) begin
                if (rst)
                    ent_reg <= `AID_IO_RST;
                else
                    ent_reg <= ent_next;
            end
            assign flat[8*gi +: 8] = ent_reg;
        end
    endgenerate

    // reads are combinational; the top registers what it needs
    assign rd_a_data = flat[{rd_a_idx, 3'b000} +: 8];
    assign rd_b_data = flat[{rd_b_idx, 3'b000} +: 8];
endmodule // aid_io_space

`default_nettype wire

// >>> rtl/aid_alu_datapath.v
/*
 * 8-bit execution unit: byte/word ops, status flags, low i/o bit access.
 * assumes one op per op_valid pulse while busy is low.
 */
// Strobed register access and the placing of the registers are this design's own decisions.
// What this block does
// - add two bytes, optional carry, five flags
// - pair plus immediate, flags with sign, two cycles
// - subtract register or immediate, five flags
// - subtract with carry, register or immediate
// - pair minus immediate, flags with sign, two cycles
// - and with register or immediate, z n v
// - or with register or immediate, z n v
// - xor two registers, z n v only
// - set mask bits by or, z n v
// - clear mask bits with inverted mask
// - test and-with-itself, flags only
// - low i/o range supports bit set/clear
// - skip tests read any low i/o bit
// - bit ops touch only the addressed bit
// - some flags of i/o entry 0x0b clear on written one
`timescale 1ns/1ps
`default_nettype none
`include "aid_consts.vh"

module aid_alu_datapath (
    input wire mclk,
    input wire rst,
    // decoder side
    input wire op_valid,
    input wire [4:0] op_code,
    input wire [7:0] op_a,
    input wire [7:0] op_b,
    input wire [7:0] op_imm,
    input wire [15:0] op_pair,
    input wire [4:0] op_io_idx,
    input wire [2:0] op_bit,
    output reg busy_reg,
    output reg res_valid_reg,
    output reg res_write_reg,
    output reg [15:0] res_word_reg,
    output reg skip_reg,
    output reg [7:0] flags_reg,
    // software side of the i/o space and status
    input wire [5:0] io_addr,
    input wire [7:0] io_wdata,
    input wire io_wr,
    input wire io_rd,
    output reg [7:0] io_rdata_reg,
    // peripheral flag set pulses for the write-one-to-clear entry
    input wire [7:0] hw_flag_set
);
    // one-hot states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WORD = 3'b010;
    localparam [2:0] ST_BIT = 3'b100;
    reg [2:0] state_reg; // control state
    reg [2:0] state_next;
    reg [4:0] op_reg; // operation held across cycles
    reg [4:0] op_next;
    reg [7:0] hi_reg; // high byte of the pair
    reg [7:0] hi_next;
    reg [7:0] lo_reg; // low result byte of the pair
    reg [7:0] lo_next;
    reg cy_reg; // carry or borrow from the low byte
    reg cy_next;
    reg [4:0] idx_reg; // i/o entry for the bit write
    reg [4:0] idx_next;
    reg [2:0] bit_reg; // bit position for the bit write
    reg [2:0] bit_next;
    reg bval_reg; // value for the bit write
    reg bval_next;
    reg [7:0] flags_next;
    reg [15:0] res_next;
    reg valid_next;
    reg write_next;
    reg skip_next;
    reg busy_next;
    // arithmetic scratch
    reg [7:0] b8; // second operand, register or immediate
    reg cin; // carry fed in
    reg [8:0] s9; // byte sum or difference with carry out
    reg [4:0] s5; // low nibble for half carry
    reg [7:0] r8; // byte result
    reg [7:0] h8; // high byte of the word result
    reg vflag; // overflow of the current operation
    // i/o space access
    wire bus_io_hit; // bus address in the bit-accessible range
    wire bus_sreg_hit; // bus address on the status register
    wire [7:0] io_bus_rd; // entry picked by the bus address
    wire [7:0] io_test_rd; // entry picked by the skip test
    wire bit_wr_en; // single-bit write this cycle
    assign bus_io_hit = (io_addr <= `AID_IO_HI);
    assign bus_sreg_hit = (io_addr == `AID_SREG_IDX);
    assign bit_wr_en = (state_reg == ST_BIT);
    aid_io_space u_io (
        .mclk(mclk),
        .rst(rst),
        .wr_en(io_wr && bus_io_hit),
        .wr_idx(io_addr[4:0]),
        .wr_data(io_wdata),
        .bit_en(bit_wr_en),
        .bit_idx(idx_reg),
        .bit_sel(bit_reg),
        .bit_val(bval_reg),
        .hw_set(hw_flag_set),
        .rd_a_idx(io_addr[4:0]),
        .rd_a_data(io_bus_rd),
        .rd_b_idx(op_io_idx),
        .rd_b_data(io_test_rd)
    );
    // next-state and datapath
    always @* begin
        state_next = state_reg;
        op_next = op_reg;
        hi_next = hi_reg;
        lo_next = lo_reg;
        cy_next = cy_reg;
        idx_next = idx_reg;
        bit_next = bit_reg;
        bval_next = bval_reg;
        flags_next = flags_reg;
        res_next = res_word_reg;
        valid_next = 1'b0;
        write_next = 1'b0;
        skip_next = 1'b0;
        busy_next = 1'b0;
        b8 = op_b;
        cin = 1'b0;
        s9 = 9'h000;
        s5 = 5'h00;
        r8 = `AID_ZERO_BYTE;
        h8 = `AID_ZERO_BYTE;
        vflag = 1'b0;
        // software writes the status register; an operation below overrides
        if (io_wr && bus_sreg_hit)
            flags_next = io_wdata;
        case (state_reg)
            ST_IDLE: begin
                if (op_valid) begin
                    // immediate forms take the constant as second operand
                    case (op_code)
                        `AID_OP_SUBTRACT_IMM, `AID_OP_SUBTRACT_IMM_WITH_CARRY,
                        `AID_OP_AND_WITH_IMM, `AID_OP_OR_WITH_IMM,
                        `AID_OP_SET_MASK_BITS: b8 = op_imm;
                        // inverted mask formed as all ones minus the mask
                        `AID_OP_CLEAR_MASK_BITS: b8 = `AID_ALL_ONES - op_imm;
                        default: b8 = op_b;
                    endcase
                    // carry in only for the with-carry forms
                    case (op_code)
                        `AID_OP_ADD_CARRY, `AID_OP_SUBTRACT_REGS_WITH_CARRY,
                        `AID_OP_SUBTRACT_IMM_WITH_CARRY: cin = flags_reg[`AID_FLAG_C];
                        default: cin = 1'b0;
                    endcase
                    valid_next = 1'b1;
                    write_next = 1'b1;
                    case (op_code)
                        `AID_OP_ADD, `AID_OP_ADD_CARRY: begin
                            s9 = {1'b0, op_a} + {1'b0, b8} + {8'h00, cin};
                            s5 = {1'b0, op_a[3:0]} + {1'b0, b8[3:0]} + {4'h0, cin};
                            r8 = s9[7:0];
                            vflag = (op_a[7] & b8[7] & ~r8[7]) | (~op_a[7] & ~b8[7] & r8[7]);
                            flags_next[`AID_FLAG_C] = s9[8];
                            flags_next[`AID_FLAG_H] = s5[4];
                        end
                        `AID_OP_SUB, `AID_OP_SUBTRACT_IMM,
                        `AID_OP_SUBTRACT_REGS_WITH_CARRY,
                        `AID_OP_SUBTRACT_IMM_WITH_CARRY: begin
                            // top bit of the wide difference is the borrow
                            s9 = {1'b0, op_a} - {1'b0, b8} - {8'h00, cin};
                            s5 = {1'b0, op_a[3:0]} - {1'b0, b8[3:0]} - {4'h0, cin};
                            r8 = s9[7:0];
                            vflag = (op_a[7] & ~b8[7] & ~r8[7]) | (~op_a[7] & b8[7] & r8[7]);
                            flags_next[`AID_FLAG_C] = s9[8];
                            flags_next[`AID_FLAG_H] = s5[4];
                        end
                        `AID_OP_AND, `AID_OP_AND_WITH_IMM,
                        `AID_OP_CLEAR_MASK_BITS: r8 = op_a & b8;
                        `AID_OP_OR, `AID_OP_OR_WITH_IMM: r8 = op_a | b8;
                        `AID_OP_SET_MASK_BITS: r8 = op_a | b8;
                        `AID_OP_XOR_REGS: r8 = op_a ^ op_b;
                        `AID_OP_TEST_REG: begin
                            // value only feeds the flags, nothing written back
                            r8 = op_a & op_a;
                            write_next = 1'b0;
                        end
                        `AID_OP_ONES_COMPLEMENT: begin
                            r8 = `AID_ALL_ONES - op_a;
                            flags_next[`AID_FLAG_C] = 1'b1;
                        end
                        `AID_OP_TWOS_COMPLEMENT: begin
                            r8 = `AID_ZERO_BYTE - op_a;
                            vflag = (r8 == `AID_MOST_NEG);
                            flags_next[`AID_FLAG_C] = (r8 != `AID_ZERO_BYTE);
                            flags_next[`AID_FLAG_H] = r8[3] | op_a[3];
                        end
                        `AID_OP_INCREMENT: begin
                            r8 = op_a + 8'h01;
                            vflag = (r8 == `AID_MOST_NEG);
                        end
                        `AID_OP_DECREMENT_REG: begin
                            r8 = op_a - 8'h01;
                            vflag = (r8 == `AID_MOST_POS);
                        end
                        `AID_OP_ZERO_REG: r8 = `AID_ZERO_BYTE;
                        `AID_OP_ADD_IMM_TO_PAIR,
                        `AID_OP_SUBTRACT_IMM_FROM_PAIR: begin
                            // low byte now, high byte next cycle
                            if (op_code == `AID_OP_ADD_IMM_TO_PAIR)
                                s9 = {1'b0, op_pair[7:0]} + {3'b000, op_imm[5:0]};
                            else
                                s9 = {1'b0, op_pair[7:0]} - {3'b000, op_imm[5:0]};
                            lo_next = s9[7:0];
                            cy_next = s9[8];
                            hi_next = op_pair[15:8];
                            op_next = op_code;
                            valid_next = 1'b0;
                            write_next = 1'b0;
                            busy_next = 1'b1;
                            state_next = ST_WORD;
                        end
                        `AID_OP_IO_BIT_SET, `AID_OP_IO_BIT_CLEAR: begin
                            // bit write lands in the second cycle
                            idx_next = op_io_idx;
                            bit_next = op_bit;
                            bval_next = (op_code == `AID_OP_IO_BIT_SET);
                            valid_next = 1'b0;
                            write_next = 1'b0;
                            busy_next = 1'b1;
                            state_next = ST_BIT;
                        end
                        `AID_OP_SKIP_IF_IO_BIT_ONE: begin
                            skip_next = io_test_rd[op_bit];
                            write_next = 1'b0;
                        end
                        `AID_OP_SKIP_IF_IO_BIT_ZERO: begin
                            skip_next = ~io_test_rd[op_bit];
                            write_next = 1'b0;
                        end
                        default: begin
                            // unknown code: no result, flags kept
                            valid_next = 1'b0;
                            write_next = 1'b0;
                        end
                    endcase
                    // z n v for every one-cycle byte operation
                    if (write_next || op_code == `AID_OP_TEST_REG) begin
                        res_next = {8'h00, r8};
                        flags_next[`AID_FLAG_Z] = (r8 == `AID_ZERO_BYTE);
                        flags_next[`AID_FLAG_N] = r8[7];
                        flags_next[`AID_FLAG_V] = vflag;
                    end
                end
            end
            ST_WORD: begin
                // high byte takes the carry or borrow of the low byte
                if (op_reg == `AID_OP_ADD_IMM_TO_PAIR) begin
                    h8 = hi_reg + {7'h00, cy_reg};
                    vflag = ~hi_reg[7] & h8[7];
                    flags_next[`AID_FLAG_C] = ~h8[7] & hi_reg[7];
                end else begin
                    h8 = hi_reg - {7'h00, cy_reg};
                    vflag = hi_reg[7] & ~h8[7];
                    flags_next[`AID_FLAG_C] = h8[7] & ~hi_reg[7];
                end
                // half carry is left alone for word operations
                flags_next[`AID_FLAG_Z] = ({h8, lo_reg} == 16'h0000);
                flags_next[`AID_FLAG_N] = h8[7];
                flags_next[`AID_FLAG_V] = vflag;
                flags_next[`AID_FLAG_S] = h8[7] ^ vflag;
                res_next = {h8, lo_reg};
                valid_next = 1'b1;
                write_next = 1'b1;
                state_next = ST_IDLE;
            end
            ST_BIT: begin
                // the i/o space performs the write this cycle
                valid_next = 1'b1;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // state and outputs
    always @(posedge mclk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            op_reg <= 5'h00;
            hi_reg <= 8'h00;
            lo_reg <= 8'h00;
            cy_reg <= 1'b0;
            idx_reg <= 5'h00;
            bit_reg <= 3'h0;
            bval_reg <= 1'b0;
            flags_reg <= `AID_FLAGS_RST;
            res_word_reg <= 16'h0000;
            res_valid_reg <= 1'b0;
            res_write_reg <= 1'b0;
            skip_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            hi_reg <= hi_next;
            lo_reg <= lo_next;
            cy_reg <= cy_next;
            idx_reg <= idx_next;
            bit_reg <= bit_next;
            bval_reg <= bval_next;
            flags_reg <= flags_next;
            res_word_reg <= res_next;
            res_valid_reg <= valid_next;
            res_write_reg <= write_next;
            skip_reg <= skip_next;
            busy_reg <= busy_next;
        end
    end

    // bus read data, valid the cycle after the strobe only
    always @(posedge mclk) begin
        if (rst) begin
            io_rdata_reg <= 8'h00;
        end else if (io_rd) begin
            if (bus_io_hit)
                io_rdata_reg <= io_bus_rd;
            else if (bus_sreg_hit)
                io_rdata_reg <= flags_reg;
            else
                io_rdata_reg <= 8'h00; // unmapped reads zero
        end else begin
            io_rdata_reg <= 8'h00;
        end
    end
endmodule // aid_alu_datapath

`default_nettype wire

// >>> test/aid_alu_checker.sv
/* concurrent checks on the datapath's decoder-side ports.
   assumes one clock mclk and a synchronous active-high rst. */
`timescale 1ns/1ps
`default_nettype none
`include "aid_consts.vh"
module aid_alu_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic op_valid,
    input wire logic [4:0] op_code,
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    input wire logic [7:0] op_imm,
    input wire logic io_wr,
    input wire logic busy_reg,
    input wire logic res_valid_reg,
    input wire logic res_write_reg,
    input wire logic [15:0] res_word_reg,
    input wire logic [7:0] flags_reg
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire take = op_valid && !busy_reg; // request taken this edge
    // two-cycle class: word ops and i/o bit writes
    wire two = op_code == `AID_OP_ADD_IMM_TO_PAIR || op_code == `AID_OP_SUBTRACT_IMM_FROM_PAIR
        || op_code == `AID_OP_IO_BIT_SET || op_code == `AID_OP_IO_BIT_CLEAR;
    AST_ONE_CYC: assert property (
        take && !two && op_code <= 5'h18 |=> res_valid_reg && !busy_reg)
        else $error("single cycle op late");
    AST_TWO_CYC: assert property (
        take && two |=> (busy_reg && !res_valid_reg) ##1 (res_valid_reg && !busy_reg))
        else $error("two cycle op timing wrong");
    AST_BUSY_ONE: assert property (busy_reg |=> !busy_reg)
        else $error("busy longer than one cycle");
    AST_ADD_SUM: assert property (
        take && op_code == `AID_OP_ADD |=> res_word_reg == {8'h00, $past(op_a) + $past(op_b)}
        && flags_reg[`AID_FLAG_Z] == (res_word_reg[7:0] == 8'h00)) else $error("add wrong");
    AST_LOGIC_V: assert property (
        take && !io_wr && (op_code == `AID_OP_AND || op_code == `AID_OP_OR_WITH_IMM)
        |=> !flags_reg[`AID_FLAG_V] && $stable(flags_reg[`AID_FLAG_C])) else $error("logic flags");
    AST_XOR: assert property (
        take && op_code == `AID_OP_XOR_REGS |=> res_word_reg == {8'h00, $past(op_a) ^ $past(op_b)})
        else $error("xor wrong");
    AST_CLR_MASK: assert property (
        take && op_code == `AID_OP_CLEAR_MASK_BITS
        |=> res_word_reg[7:0] == ($past(op_a) & (`AID_ALL_ONES - $past(op_imm)))) else $error("mask");
    AST_COM: assert property (
        take && op_code == `AID_OP_ONES_COMPLEMENT
        |=> res_word_reg[7:0] == ~$past(op_a) && flags_reg[`AID_FLAG_C]) else $error("complement");
    AST_TEST_NOWR: assert property (
        take && op_code == `AID_OP_TEST_REG |=> res_valid_reg && !res_write_reg)
        else $error("test wrote back");
    // main traffic kinds
    cover property (take && two);
    cover property (take && op_code == `AID_OP_ADD_CARRY);
    cover property (res_valid_reg && !res_write_reg);
endmodule // aid_alu_checker
bind aid_alu_datapath aid_alu_checker u_chk (.*);
`default_nettype wire

// >>> test/aid_dec_model.sv
/* decoder and register file model: issues one op, takes the answer.
   assumes an answer within four cycles. */
`timescale 1ns/1ps
`default_nettype none
module aid_dec_model (
    input wire logic mclk,
    input wire logic res_valid_reg,
    input wire logic res_write_reg,
    input wire logic [15:0] res_word_reg,
    input wire logic skip_reg,
    output logic op_valid,
    output logic [4:0] op_code,
    output logic [7:0] op_a,
    output logic [7:0] op_b,
    output logic [7:0] op_imm,
    output logic [15:0] op_pair,
    output logic [4:0] op_io_idx,
    output logic [2:0] op_bit
);
    logic [15:0] wb_word; // written-back result
    logic wb_wr; // write-back request seen
    logic wb_skip; // skip decision seen
    logic [3:0] wb_lat; // cycles from taking edge to answer
    initial {op_valid, op_code, op_a, op_b, op_imm, op_pair, op_io_idx, op_bit} = '0;
    // fields scrambled after the taking edge
    task automatic issue(input logic [4:0] c, input logic [7:0] a, b, k,
            input logic [4:0] idx = 5'h00, input logic [2:0] bn = 3'h0);
        @(posedge mclk);
        op_valid <= 1'b1;
        op_code <= c;
        {op_a, op_b, op_imm, op_pair, op_io_idx, op_bit} <= {a, b, k, a, b, idx, bn};
        @(posedge mclk);
        op_valid <= 1'b0;
        {op_a, op_b, op_imm, op_pair, op_io_idx, op_bit} <= ~{a, b, k, a, b, idx, bn};
        wb_lat = 4'h0;
        do begin
            @(negedge mclk);
            wb_lat++;
        end while (res_valid_reg !== 1'b1 && wb_lat < 4'h4);
        {wb_word, wb_wr, wb_skip} = {res_word_reg, res_write_reg, skip_reg};
    endtask
endmodule // aid_dec_model
`default_nettype wire

// >>> test/aid_alu_datapath_tb.sv
/* self-checking bench: ops via the decoder model, i/o via the bus.
   assumes a 200 MHz mclk. */
`timescale 1ns/1ps
`default_nettype none
`include "aid_consts.vh"
module aid_alu_datapath_tb;
    logic mclk, rst, op_valid, busy_reg, res_valid_reg, res_write_reg, skip_reg, io_wr, io_rd;
    logic [4:0] op_code, op_io_idx;
    logic [2:0] op_bit;
    logic [7:0] op_a, op_b, op_imm, flags_reg, io_wdata, io_rdata_reg, hw_flag_set, rd;
    logic [15:0] op_pair, res_word_reg;
    logic [5:0] io_addr;
    int errors = 0, tests_run = 0, cycles = 0;
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    aid_alu_datapath dut (.*);
    aid_dec_model dec (.*);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // write data scrambled once released
    task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        {io_wr, io_addr, io_wdata} <= {1'b1, a, d};
        @(posedge mclk);
        {io_wr, io_wdata} <= {1'b0, ~d};
    endtask
    task automatic bus_rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge mclk);
        {io_rd, io_addr} <= {1'b1, a};
        @(posedge mclk);
        io_rd <= 1'b0;
        @(negedge mclk);
        d = io_rdata_reg;
    endtask
    // preset flags, run one op, compare
    task automatic run(input logic [4:0] c, input logic [7:0] a, b, k, fin,
            input logic [15:0] ew, input logic [7:0] ef);
        logic two;
        two = c == `AID_OP_ADD_IMM_TO_PAIR || c == `AID_OP_SUBTRACT_IMM_FROM_PAIR;
        bus_wr(`AID_SREG_IDX, fin);
        dec.issue(c, a, b, k);
        chk(dec.wb_lat, two ? `AID_CYC_WORD : `AID_CYC_BYTE);
        chk(flags_reg, ef);
        chk(dec.wb_wr, c != `AID_OP_TEST_REG);
        if (c != `AID_OP_TEST_REG)
            chk(dec.wb_word, ew);
    endtask
    // bit write, read back
    task automatic bit_op(input logic [4:0] c, idx, input logic [2:0] bn, input logic [7:0] e);
        dec.issue(c, 8'h00, 8'h00, 8'h00, idx, bn);
        chk(dec.wb_lat, `AID_CYC_BIT);
        chk(dec.wb_wr, 1'b0);
        bus_rd({1'b0, idx}, rd);
        chk(rd, e);
    endtask
    task automatic skip(input logic [4:0] c, idx, input logic [2:0] bn, input logic e);
        dec.issue(c, 8'h00, 8'h00, 8'h00, idx, bn);
        chk(dec.wb_lat, `AID_CYC_BYTE);
        chk(dec.wb_skip, e);
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        rst = 1'b1;
        {io_wr, io_rd, io_addr, io_wdata, hw_flag_set} = '0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        chk(flags_reg, `AID_FLAGS_RST);
        bus_rd(6'h0b, rd);
        chk(rd, `AID_IO_RST);
        run(`AID_OP_ADD, 8'h0f, 8'h01, 8'h00, 8'h00, 16'h0010, 8'h20);
        run(`AID_OP_ADD_CARRY, 8'h7f, 8'h00, 8'h00, 8'h01, 16'h0080, 8'h2c);
        run(`AID_OP_ADD_IMM_TO_PAIR, 8'hff, 8'hff, 8'hc1, 8'h20, 16'h0000, 8'h23);
        run(`AID_OP_SUB, 8'h00, 8'h01, 8'h00, 8'h10, 16'h00ff, 8'h35);
        run(`AID_OP_SUBTRACT_IMM, 8'h80, 8'h00, 8'h01, 8'h00, 16'h007f, 8'h28);
        run(`AID_OP_SUBTRACT_REGS_WITH_CARRY, 8'h05, 8'h05, 8'h00, 8'h01, 16'h00ff, 8'h25);
        run(`AID_OP_SUBTRACT_IMM_WITH_CARRY, 8'h10, 8'h00, 8'h0f, 8'h02, 16'h0001, 8'h20);
        run(`AID_OP_SUBTRACT_IMM_FROM_PAIR, 8'h80, 8'h00, 8'h01, 8'h00, 16'h7fff, 8'h18);
        run(`AID_OP_AND, 8'hf0, 8'h3c, 8'h00, 8'h09, 16'h0030, 8'h01);
        run(`AID_OP_AND_WITH_IMM, 8'haa, 8'h00, 8'h55, 8'h00, 16'h0000, 8'h02);
        run(`AID_OP_OR, 8'h80, 8'h01, 8'h00, 8'h00, 16'h0081, 8'h04);
        run(`AID_OP_OR_WITH_IMM, 8'h00, 8'hff, 8'h00, 8'h00, 16'h0000, 8'h02);
        run(`AID_OP_XOR_REGS, 8'h5a, 8'h5a, 8'h00, 8'h21, 16'h0000, 8'h23);
        run(`AID_OP_SET_MASK_BITS, 8'h40, 8'h00, 8'h81, 8'h00, 16'h00c1, 8'h04);
        run(`AID_OP_CLEAR_MASK_BITS, 8'hff, 8'h00, 8'h0f, 8'h00, 16'h00f0, 8'h04);
        run(`AID_OP_TEST_REG, 8'h80, 8'h00, 8'h00, 8'h08, 16'h0080, 8'h04);
        run(`AID_OP_ONES_COMPLEMENT, 8'hff, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h03);
        run(`AID_OP_TWOS_COMPLEMENT, 8'h01, 8'h00, 8'h00, 8'h00, 16'h00ff, 8'h25);
        run(`AID_OP_INCREMENT, 8'h7f, 8'h00, 8'h00, 8'h01, 16'h0080, 8'h0d);
        run(`AID_OP_DECREMENT_REG, 8'h00, 8'h00, 8'h00, 8'h01, 16'h00ff, 8'h05);
        run(`AID_OP_ZERO_REG, 8'h55, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h02);
        bus_rd(`AID_SREG_IDX, rd);
        chk(rd, 8'h02);
        bus_wr(6'h03, 8'h81);
        bit_op(`AID_OP_IO_BIT_SET, 5'h03, 3'h5, 8'ha1);
        bit_op(`AID_OP_IO_BIT_CLEAR, 5'h03, 3'h7, 8'h21);
        bit_op(`AID_OP_IO_BIT_SET, `AID_IO_HI, 3'h0, 8'h01);
        skip(`AID_OP_SKIP_IF_IO_BIT_ONE, 5'h03, 3'h5, 1'b1);
        skip(`AID_OP_SKIP_IF_IO_BIT_ZERO, 5'h03, 3'h5, 1'b0);
        skip(`AID_OP_SKIP_IF_IO_BIT_ZERO, 5'h03, 3'h7, 1'b1);
        @(posedge mclk);
        hw_flag_set <= 8'h21;
        @(posedge mclk);
        hw_flag_set <= 8'h00;
        bus_rd(6'h0b, rd);
        chk(rd, 8'h21);
        bus_wr(6'h0b, 8'h01);
        bus_rd(6'h0b, rd);
        chk(rd, 8'h20);
        bit_op(`AID_OP_IO_BIT_CLEAR, `AID_W1C_IDX, 3'h5, 8'h20);
        bit_op(`AID_OP_IO_BIT_SET, `AID_W1C_IDX, 3'h4, 8'h30);
        bit_op(`AID_OP_IO_BIT_SET, `AID_W1C_IDX, 3'h5, 8'h10);
        bus_rd(6'h20, rd);
        chk(rd, 8'h00);
        wrap_up();
    end
endmodule // aid_alu_datapath_tb
`default_nettype wire
